// >>> hdl/cra_pkg.sv
/*
 constants, types and helpers of the CAN receive path with acceptance filter.
 assumes one clock; frame fields come already decoded from the bit engine.
*/
package cra_pkg;

   // ==========================================
   // widths and depths
   localparam int ID_W = 29;
   localparam int STD_ID_W = 11;
   localparam int DLC_W = 4;
   localparam int DATA_W = 64;
   localparam int HIT_W = 3;
   localparam int BANK_W = 32;
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 3'h4;

   // ==========================================
   // reset values
   localparam logic [HIT_W-1:0] HIT_RESET = 3'h0;

   // ==========================================
   // filter modes
   typedef enum logic [1:0] {
      MODE_TWO_WIDE,
      MODE_FOUR_HALF,
      MODE_EIGHT_BYTE,
      MODE_CLOSED
   } cra_mode_e;

   // ==========================================
   // stored frame
   typedef struct packed {
      logic [ID_W-1:0] id;
      logic ide;
      logic rtr;
      logic [DLC_W-1:0] dlc;
      logic [DATA_W-1:0] data;
      logic [HIT_W-1:0] hit;
   } cra_entry_s;

   localparam int ENTRY_W = $bits(cra_entry_s);

   // ==========================================
   // identifier laid out as the filter sees it, msb first
   function automatic logic [WORD_W-1:0] filter_word(input logic [ID_W-1:0] id,
         input logic ide, input logic rtr, input logic srr);
      if (ide) begin
         filter_word = {id[28:18], srr, 1'b1, id[17:0], rtr};
      end else begin
         filter_word = {id[STD_ID_W-1:0], rtr, 1'b0, 19'h0_0000};
      end
   endfunction

endpackage

// >>> hdl/cra_accept_filter.sv
/*
 identifier acceptance filter: pattern and mask banks, four modes.
 assumes banks are stable while a frame is being judged.
*/
`timescale 1ns/1ns
module cra_accept_filter (
   // configuration
   input wire cra_pkg::cra_mode_e mode,
   input wire logic [2*cra_pkg::BANK_W-1:0] pattern,
   input wire logic [2*cra_pkg::BANK_W-1:0] mask,
   // frame under test
   input wire logic [cra_pkg::WORD_W-1:0] word,
   // result
   output logic hit,
   output logic [cra_pkg::HIT_W-1:0] hitIndex
);

   // ==========================================
   // matching
   // equal or masked
   function automatic logic bits_match(input logic [31:0] p, input logic [31:0] m,
         input logic [31:0] w);
      bits_match = &(~(p ^ w) | m);
   endfunction

   always_comb begin
      hit = 1'b0;
      hitIndex = cra_pkg::HIT_RESET;
      unique case (mode)
         cra_pkg::MODE_TWO_WIDE: begin
            // bank 0 filter 0, bank 1 filter 1
            for (int i = 1; i >= 0; i--) begin
               if (bits_match(pattern[63-32*i -: 32], mask[63-32*i -: 32], word)) begin
                  hit = 1'b1;
                  hitIndex = 3'(i);
               end
            end
         end
         cra_pkg::MODE_FOUR_HALF: begin
            for (int i = 3; i >= 0; i--) begin
               if (bits_match({pattern[63-16*i -: 16], 16'h0000},
                     {mask[63-16*i -: 16], 16'hFFFF}, word)) begin
                  hit = 1'b1;
                  hitIndex = 3'(i);
               end
            end
         end
         cra_pkg::MODE_EIGHT_BYTE: begin
            for (int i = 7; i >= 0; i--) begin
               if (bits_match({pattern[63-8*i -: 8], 24'h00_0000},
                     {mask[63-8*i -: 8], 24'hFF_FFFF}, word)) begin
                  hit = 1'b1;
                  hitIndex = 3'(i);
               end
            end
         end
         cra_pkg::MODE_CLOSED: begin
            hit = 1'b0;
         end
      endcase
   end

endmodule

// >>> hdl/cra_two_buffer.sv
/*
 two-entry buffer with valid and ready on both sides, registered outputs.
 assumes the drain side may stall indefinitely.
*/
`timescale 1ns/1ns
module cra_two_buffer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clockEn,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   typedef struct packed {
      logic valid0;
      logic valid1;
      logic [WIDTH-1:0] data0;
      logic [WIDTH-1:0] data1;
   } cra_buf_state_s;

   cra_buf_state_s q;
   cra_buf_state_s d;

   // ==========================================
   // next state
   always_comb begin
      d = q;
      if (q.valid0 && outReady) begin
         d.data0 = q.data1;
         d.valid0 = q.valid1;
         d.valid1 = 1'b0;
      end
      if (inValid && !q.valid1) begin
         if (!d.valid0) begin
            d.data0 = inData;
            d.valid0 = 1'b1;
         end else begin
            d.data1 = inData;
            d.valid1 = 1'b1;
         end
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (clockEn) begin
         q <= d;
      end
   end

   assign inReady = !q.valid1;
   assign outValid = q.valid0;
   assign outData = q.data0;

endmodule

// >>> hdl/cra_rx_path.sv
/*
 CAN receive path: background buffer, acceptance, receive FIFO, overrun.
 assumes a bit engine on the same clock delivers decoded frames with an
 end pulse, and a host draining frames through a valid/ready port.
*/
`timescale 1ns/1ns
module cra_rx_path (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clockEn,
   // configuration
   input wire cra_pkg::cra_mode_e filterMode,
   input wire logic [cra_pkg::BANK_W-1:0] acceptancePatternBank0,
   input wire logic [cra_pkg::BANK_W-1:0] acceptancePatternBank1,
   input wire logic [cra_pkg::BANK_W-1:0] acceptanceMaskBank0,
   input wire logic [cra_pkg::BANK_W-1:0] acceptanceMaskBank1,
   input wire logic loopbackEn,
   input wire logic overrunIrqEn,
   // transmit status
   input wire logic txStart,
   input wire logic arbLost,
   // frame from bit engine
   input wire logic frameEnd,
   input wire logic frameOk,
   input wire logic [cra_pkg::ID_W-1:0] frameId,
   input wire logic frameIde,
   input wire logic frameRtr,
   input wire logic frameSrr,
   input wire logic [cra_pkg::DLC_W-1:0] frameDlc,
   input wire logic [cra_pkg::DATA_W-1:0] frameData,
   // bus side answer
   output logic ackEnable,
   // host read port
   output logic receiveFullFlag,
   input wire logic rxOutReady,
   output logic [cra_pkg::ID_W-1:0] rxOutId,
   output logic rxOutIde,
   output logic rxOutRtr,
   output logic [cra_pkg::DLC_W-1:0] rxOutDlc,
   output logic [cra_pkg::DATA_W-1:0] rxOutData,
   output logic [cra_pkg::HIT_W-1:0] rxOutHit,
   // status
   output logic [cra_pkg::HIT_W-1:0] filterHitIndex,
   output logic rxEvent,
   output logic overrunEvent
);

   typedef struct packed {
      logic bgValid;
      logic bgOk;
      logic bgOwn;
      logic [cra_pkg::ID_W-1:0] bgId;
      logic bgIde;
      logic bgRtr;
      logic bgSrr;
      logic [cra_pkg::DLC_W-1:0] bgDlc;
      logic [cra_pkg::DATA_W-1:0] bgData;
      logic ownTx;
      logic ackEnable;
      cra_pkg::cra_entry_s [cra_pkg::FIFO_DEPTH-1:0] fifo;
      logic [cra_pkg::PTR_W-1:0] wrPtr;
      logic [cra_pkg::PTR_W-1:0] rdPtr;
      logic [cra_pkg::CNT_W-1:0] count;
      logic [cra_pkg::HIT_W-1:0] hitIndex;
      logic rxEvent;
      logic overrunEvent;
   } cra_rx_state_s;

   cra_rx_state_s q;
   cra_rx_state_s d;

   logic filterHit;
   logic [cra_pkg::HIT_W-1:0] filterIdx;
   logic bufInReady;
   logic bufInValid;
   logic [cra_pkg::ENTRY_W-1:0] bufInData;
   logic [cra_pkg::ENTRY_W-1:0] bufOutData;
   cra_pkg::cra_entry_s head;
   logic popFire;
   logic pushFire;
   logic fullNow;
   logic candidate;

   // ==========================================
   // acceptance filter
   // pattern and mask banks
   cra_accept_filter filter (
      .mode(filterMode),
      .pattern({acceptancePatternBank0, acceptancePatternBank1}),
      .mask({acceptanceMaskBank0, acceptanceMaskBank1}),
      .word(cra_pkg::filter_word(q.bgId, q.bgIde, q.bgRtr, q.bgSrr)),
      .hit(filterHit),
      .hitIndex(filterIdx)
   );

   // ==========================================
   // next state
   always_comb begin
      d = q;
      d.rxEvent = 1'b0;
      d.overrunEvent = 1'b0;

      if (txStart) begin
         d.ownTx = 1'b1;
      end
      if (arbLost) begin
         d.ownTx = 1'b0;
      end

      d.ackEnable = !(d.ownTx && !loopbackEn);

      // fifo head to output buffer
      bufInValid = (q.count != '0);
      bufInData = q.fifo[q.rdPtr];
      popFire = bufInValid && bufInReady;

      // own frame outside loopback stays back
      candidate = q.bgValid && q.bgOk && (!q.bgOwn || loopbackEn) && filterHit;
      // a slot freed this cycle counts
      fullNow = (q.count == cra_pkg::FIFO_FULL_CNT) && !popFire;
      pushFire = 1'b0;
      if (q.bgValid) begin
         d.bgValid = 1'b0;
      end
      if (candidate) begin
         if (fullNow) begin
            d.overrunEvent = overrunIrqEn;
         end else begin
            pushFire = 1'b1;
            d.fifo[q.wrPtr] = '{id: q.bgId, ide: q.bgIde, rtr: q.bgRtr, dlc: q.bgDlc,
                                data: q.bgData, hit: filterIdx};
            d.wrPtr = q.wrPtr + 2'h1;
            d.hitIndex = filterIdx;
            d.rxEvent = 1'b1;
         end
      end

      if (popFire) begin
         d.rdPtr = q.rdPtr + 2'h1;
      end
      if (pushFire && !popFire) begin
         d.count = q.count + 3'h1;
      end else if (popFire && !pushFire) begin
         d.count = q.count - 3'h1;
      end

      // background always overwritten by next frame
      // winning frame captured like any other
      if (frameEnd) begin
         d.bgValid = 1'b1;
         d.bgOk = frameOk;
         d.bgOwn = q.ownTx && !arbLost;
         d.bgId = frameId;
         d.bgIde = frameIde;
         d.bgRtr = frameRtr;
         d.bgSrr = frameSrr;
         d.bgDlc = frameDlc;
         d.bgData = frameData;
         d.ownTx = 1'b0;
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.ackEnable <= 1'b1;
         q.hitIndex <= cra_pkg::HIT_RESET;
      end else if (clockEn) begin
         q <= d;
      end
   end

   // ==========================================
   // host output buffer
   // full flag is output buffer valid
   cra_two_buffer #(
      .WIDTH(cra_pkg::ENTRY_W)
   ) outBuf (
      .clock(clock),
      .rst_b(rst_b),
      .clockEn(clockEn),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(bufInData),
      .outValid(receiveFullFlag),
      .outReady(rxOutReady),
      .outData(bufOutData)
   );

   assign head = bufOutData;
   assign rxOutId = head.id;
   assign rxOutIde = head.ide;
   assign rxOutRtr = head.rtr;
   assign rxOutDlc = head.dlc;
   assign rxOutData = head.data;
   assign rxOutHit = head.hit;
   assign ackEnable = q.ackEnable;
   assign filterHitIndex = q.hitIndex;
   assign rxEvent = q.rxEvent;
   assign overrunEvent = q.overrunEvent;

endmodule

// >>> bench/cra_bus_node.sv
/*
 bus-side node model: hands over decoded frames and transmit status.
 assumes the bench calls its tasks and supplies the clock.
*/
`timescale 1ns/1ns
module cra_bus_node (
   // clock
   input wire logic clock,
   // transmit status
   output logic txStart,
   output logic arbLost,
   // decoded frame
   output logic frameEnd,
   output logic frameOk,
   output logic frameIde,
   output logic frameRtr,
   output logic frameSrr,
   output logic [28:0] frameId,
   output logic [3:0] frameDlc,
   output logic [63:0] frameData
);
   initial {txStart, arbLost, frameEnd, frameOk, frameIde, frameRtr, frameSrr} = '0;
   initial {frameId, frameDlc, frameData} = '0;
   task send(input logic [28:0] id, input logic ide, rtr, srr, ok, input logic [3:0] dlc,
         input logic [63:0] data);
      @(posedge clock);
      #2;
      {frameId, frameIde, frameRtr, frameSrr, frameOk, frameEnd} = {id, ide, rtr, srr, ok, 1'b1};
      frameDlc = dlc;
      frameData = data;
      @(posedge clock);
      #2;
      frameEnd = 1'b0;
      // released fields show the inverse
      {frameId, frameDlc, frameData} = ~{frameId, frameDlc, frameData};
   endtask
   task pulse(input logic lost);
      @(posedge clock);
      #2;
      if (lost) arbLost = 1'b1;
      else txStart = 1'b1;
      @(posedge clock);
      #2;
      {txStart, arbLost} = 2'h0;
   endtask
endmodule

// >>> bench/cra_rx_checker.sv
/*
 checker for the receive path ports.
 assumes binding onto cra_rx_path, one clock.
*/
`timescale 1ns/1ns
module cra_rx_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // inputs watched
   input wire cra_pkg::cra_mode_e filterMode,
   input wire logic loopbackEn,
   input wire logic overrunIrqEn,
   input wire logic txStart,
   input wire logic arbLost,
   input wire logic frameEnd,
   input wire logic frameOk,
   input wire logic rxOutReady,
   // outputs watched
   input wire logic ackEnable,
   input wire logic receiveFullFlag,
   input wire logic [28:0] rxOutId,
   input wire logic [2:0] rxOutHit,
   input wire logic [2:0] filterHitIndex,
   input wire logic rxEvent,
   input wire logic overrunEvent
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic ownQ;
   // own frame on the bus
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) ownQ <= 1'b0;
      else if (txStart) ownQ <= 1'b1;
      else if (frameEnd || arbLost) ownQ <= 1'b0;
   end
   a_bad_silent: assert property ((rxEvent || overrunEvent) |-> $past(frameEnd && frameOk, 2))
      else $error("event without good frame");
   a_own_noack: assert property (ownQ && !loopbackEn |-> !ackEnable)
      else $error("own frame acknowledged");
   a_own_drop: assert property (frameEnd && ownQ && !arbLost && !loopbackEn
      |-> ##2 !rxEvent)
      else $error("own frame stored");
   a_lost_ack: assert property (arbLost |=> ackEnable)
      else $error("no ack after lost arbitration");
   a_store_flag: assert property (rxEvent |-> ##[1:3] receiveFullFlag)
      else $error("stored frame not flagged");
   a_out_hold: assert property (receiveFullFlag && !rxOutReady |=> receiveFullFlag
      && $stable(rxOutId) && $stable(rxOutHit))
      else $error("output changed while waiting");
   a_drop_full: assert property (overrunEvent |-> receiveFullFlag && $past(overrunIrqEn))
      else $error("overrun while not full or disabled");
   a_closed_drop: assert property (frameEnd && filterMode == cra_pkg::MODE_CLOSED
      |-> ##2 !rxEvent)
      else $error("closed mode accepted");
   a_wide_index: assert property (rxEvent && filterMode == cra_pkg::MODE_TWO_WIDE
      |-> filterHitIndex < 3'h2)
      else $error("wide mode index out of range");
endmodule
bind cra_rx_path cra_rx_checker chk (.clock, .rst_b, .filterMode, .loopbackEn, .overrunIrqEn,
   .txStart, .arbLost, .frameEnd, .frameOk, .rxOutReady, .ackEnable, .receiveFullFlag,
   .rxOutId, .rxOutHit, .filterHitIndex, .rxEvent, .overrunEvent);

// >>> bench/cra_rx_path_tb.sv
/*
 self-checking bench of the receive path with a bus node model.
 assumes the checker is bound and the design is on one 20 MHz clock.
*/
`timescale 1ns/1ns
module cra_rx_path_tb;
   logic clock = 0, rst_b = 0, loopbackEn = 0, overrunIrqEn = 1, rxOutReady = 1;
   cra_pkg::cra_mode_e filterMode = cra_pkg::MODE_TWO_WIDE;
   logic [31:0] p0 = 0, p1 = 0, m0 = 0, m1 = 0;
   logic frameEnd, frameOk, frameIde, frameRtr, frameSrr, txStart, arbLost, ackEnable;
   logic receiveFullFlag, rxOutIde, rxOutRtr, rxEvent, overrunEvent;
   logic [28:0] frameId, rxOutId, id;
   logic [3:0] frameDlc, rxOutDlc;
   logic [63:0] frameData, rxOutData;
   logic [2:0] rxOutHit, filterHitIndex;
   int err_total = 0, total_checks = 0;
   logic [3:0] evQ[$];
   logic [31:0] idQ[$];
   logic [69:0] pdQ[$];
   always #25 clock = ~clock;
   cra_bus_node node (.clock, .txStart, .arbLost, .frameEnd, .frameOk, .frameIde, .frameRtr,
      .frameSrr, .frameId, .frameDlc, .frameData);
   cra_rx_path dut (.clock, .rst_b, .clockEn(1'b1), .filterMode, .acceptancePatternBank0(p0),
      .acceptancePatternBank1(p1), .acceptanceMaskBank0(m0), .acceptanceMaskBank1(m1),
      .loopbackEn, .overrunIrqEn, .txStart, .arbLost, .frameEnd, .frameOk, .frameId, .frameIde,
      .frameRtr, .frameSrr, .frameDlc, .frameData, .ackEnable, .receiveFullFlag, .rxOutReady,
      .rxOutId, .rxOutIde, .rxOutRtr, .rxOutDlc, .rxOutData, .rxOutHit, .filterHitIndex,
      .rxEvent, .overrunEvent);
   // ==========================================
   // compares and expectations
   task cmp_ev(input logic [3:0] e, s);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH event exp %h seen %h", e, s);
      end
   endtask
   task cmp_id(input logic [31:0] e, s);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH frame exp %h seen %h", e, s);
      end
   endtask
   task cmp_pd(input logic [69:0] e, s);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH payload exp %h seen %h", e, s);
      end
   endtask
   function logic [31:0] fw(logic [28:0] i, logic ide, rtr, srr);
      fw = ide ? {i[28:18], srr, 1'b1, i[17:0], rtr} : {i[10:0], rtr, 1'b0, 19'h0_0000};
   endfunction
   task fr(input logic [28:0] i, input logic ide, ok, own);
      logic rtr, srr;
      logic [31:0] w;
      logic [3:0] h;
      logic [3:0] dl;
      logic [63:0] dt;
      rtr = 1'($urandom);
      srr = 1'($urandom);
      dl = 4'($urandom);
      dt = {$urandom, $urandom};
      if (!ide) i = 29'(i[10:0]);
      w = fw(i, ide, rtr, srr);
      h = ((w ^ p0) & ~m0) == 0 ? 4'h0 : ((w ^ p1) & ~m1) == 0 ? 4'h1 : 4'hf;
      if (!ok || own || filterMode == cra_pkg::MODE_CLOSED) h = 4'hf;
      if (h != 4'hf && idQ.size() >= 6) h = overrunIrqEn ? 4'h8 : 4'hf;
      if (h < 4'h8) begin
         idQ.push_back({h[2:0], i});
         pdQ.push_back({ide, rtr, dl, dt});
      end
      if (h != 4'hf) evQ.push_back(h);
      node.send(i, ide, rtr, srr, ok, dl, dt);
      // let the judge edge pass before settings move
      @(posedge clock);
      #2;
   endtask
   task gap(input int n);
      repeat (12) @(posedge clock);
      #2;
      $display("test %0d done", n);
   endtask
   always @(negedge clock) begin
      if (rxEvent === 1'b1) cmp_ev(evQ.size() ? evQ.pop_front() : 4'he, {1'b0, filterHitIndex});
      if (overrunEvent === 1'b1) cmp_ev(evQ.size() ? evQ.pop_front() : 4'he, 4'h8);
      if (receiveFullFlag === 1'b1 && rxOutReady) begin
         cmp_id(idQ.size() ? idQ.pop_front() : '1, {rxOutHit, rxOutId});
         cmp_pd(pdQ.size() ? pdQ.pop_front() : '1,
            {rxOutIde, rxOutRtr, rxOutDlc, rxOutData});
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      close_out();
   end
   // ==========================================
   // scenarios
   initial begin
      void'($urandom(32'h89cc_7f53));
      id = 29'($urandom);
      m0 = $urandom | 32'h0010_0001;
      p0 = fw(id, 1'b1, 1'b0, 1'b0);
      p1 = $urandom;
      m1 = '1;
      repeat (16) @(posedge clock);
      #2 rst_b = 1;
      for (int i = 0; i < 16; i++) begin
         if (i == 8) m1 = '0;
         fr(i[0] ? 29'($urandom) : id ^ (29'h1 << ($urandom % 29)), i % 4 != 3, 1'b1, 1'b0);
      end
      gap(1);
      fr(id, 1'b1, 1'b0, 1'b0);
      fr(id, 1'b1, 1'b1, 1'b0);
      gap(2);
      node.pulse(1'b0);
      fr(id, 1'b1, 1'b1, 1'b1);
      loopbackEn = 1;
      node.pulse(1'b0);
      fr(id, 1'b1, 1'b1, 1'b0);
      loopbackEn = 0;
      node.pulse(1'b0);
      node.pulse(1'b1);
      fr(id, 1'b1, 1'b1, 1'b0);
      gap(3);
      rxOutReady = 0;
      m1 = '1;
      for (int i = 0; i < 8; i++) begin
         if (i == 7) overrunIrqEn = 0;
         fr(id ^ 29'(i), 1'b1, 1'b1, 1'b0);
      end
      rxOutReady = 1;
      @(posedge clock);
      #2 rxOutReady = 0;
      repeat (4) @(posedge clock);
      fr(id, 1'b1, 1'b1, 1'b0);
      rxOutReady = 1;
      overrunIrqEn = 1;
      gap(4);
      {m0, m1} = '1;
      for (int k = 1; k < 4; k++) begin
         filterMode = cra_pkg::cra_mode_e'(k);
         fr(29'($urandom), 1'b0, 1'b1, 1'b0);
         repeat (4) @(posedge clock);
         #2;
      end
      gap(5);
      cmp_ev(4'(evQ.size() + idQ.size() + pdQ.size()), 4'h0);
      close_out();
   end
endmodule
